// [logic/dcbf_top.sv]
// Two-way clocked queue buffer with mailboxes; side A doubles as the APB offset port.
//
// Operation
// - Two 512x36 queues, one each direction.
// - Two 36-bit mailbox registers bypass the queues.
// - Each mailbox has a flag showing unread mail.
// - Each queue shows empty, full, almost-full and almost-empty.
// - Transfers happen on rising side clock edges qualified by select and gate.
// - Side clocks are independent, asynchronous or coincident.
// - Input-ready and almost-full pass two flops on the writing clock.
// - Output-ready and almost-empty pass two flops on the reading clock.
// - Side A flags change only on side A clock edges.
// - Side B flags change only on side B clock edges.
// - All four offsets are programmed from side A only.
// - Side A almost-empty low when b-to-a words at or below offset.
// - Side B almost-empty low when a-to-b words at or below offset.
// - Side A almost-full low when a-to-b free space at or below offset.
// - Side B almost-full low when b-to-a free space at or below offset.
// - Side A data outputs released whenever side A select is high.
// - Each side uses its own 36-bit two-way data bus.
// - Side A input-ready low while a-to-b full; rises after reset.
// - Side A output-ready rises third edge after word enters empty queue.
// - A-to-b mailbox flag falls on write, blocks writes, rises on B read.
//
// Implementation choices: the placing of the registers and register access over APB.
module dcbf_top (
    // Side A clock and reset
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    // APB offset and status registers
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [dcbf_pkg::PADDR_W-1:0]   paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    // Side A pins
    input  wire dcbf_pkg::dcbf_side_in_t        side_a_in,
    output dcbf_pkg::dcbf_side_out_t            side_a_out,
    // Side B pins
    input  wire logic                           side_b_clock,
    input  wire dcbf_pkg::dcbf_side_in_t        side_b_in,
    output dcbf_pkg::dcbf_side_out_t            side_b_out
);
    import dcbf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Each domain releases reset on its own clock so the queue flags leave
    // reset cleanly even when the two clocks are unrelated.
    logic [1:0] a_rst_q, b_rst_q;
    logic       a_rst_n, b_rst_n;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_rst_q <= 2'h0;
        end else begin
            a_rst_q <= {a_rst_q[0], 1'b1};
        end
    end

    always_ff @(posedge side_b_clock or negedge presetn) begin
        if (!presetn) begin
            b_rst_q <= 2'h0;
        end else begin
            b_rst_q <= {b_rst_q[0], 1'b1};
        end
    end

    assign a_rst_n = a_rst_q[1];
    assign b_rst_n = b_rst_q[1];

    ////////////////////////////////////////////////////////////////////////////
    logic a_go, a_wr, a_rd, b_go, b_wr, b_rd;

    assign a_go = ~side_a_in.select_n & side_a_in.transfer_gate;
    assign a_wr = a_go & side_a_in.write_sel;
    assign a_rd = a_go & ~side_a_in.write_sel;
    assign b_go = ~side_b_in.select_n & side_b_in.transfer_gate;
    assign b_wr = b_go & side_b_in.write_sel;
    assign b_rd = b_go & ~side_b_in.write_sel;

    ////////////////////////////////////////////////////////////////////////////
    logic [THR_W-1:0] a2b_empty_threshold_q, a2b_full_threshold_q;
    logic [THR_W-1:0] b2a_empty_threshold_q, b2a_full_threshold_q;
    logic [CNT_W-1:0] a2b_count, b2a_count;
    logic             apb_wr, apb_setup, hit_a2b_ae, hit_a2b_af, hit_b2a_ae, hit_b2a_af, hit_status;
    logic             mapped;
    logic [31:0]      rd_mux;

    assign apb_wr     = psel & penable & pwrite;
    assign apb_setup  = psel & ~penable;
    assign hit_a2b_ae = paddr == OFF_A2B_AE;
    assign hit_a2b_af = paddr == OFF_A2B_AF;
    assign hit_b2a_ae = paddr == OFF_B2A_AE;
    assign hit_b2a_af = paddr == OFF_B2A_AF;
    assign hit_status = paddr == OFF_STATUS;
    assign mapped     = hit_a2b_ae | hit_a2b_af | hit_b2a_ae | hit_b2a_af | hit_status;
    assign pready     = 1'b1;
    assign pslverr    = psel & penable & ~mapped;

    assign rd_mux = hit_a2b_ae ? {23'h0, a2b_empty_threshold_q} :
                    hit_a2b_af ? {23'h0, a2b_full_threshold_q} :
                    hit_b2a_ae ? {23'h0, b2a_empty_threshold_q} :
                    hit_b2a_af ? {23'h0, b2a_full_threshold_q} :
                    hit_status ? {6'h0, b2a_count, 6'h0, a2b_count} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a2b_empty_threshold_q <= THR_RESET;
            a2b_full_threshold_q  <= THR_RESET;
            b2a_empty_threshold_q <= THR_RESET;
            b2a_full_threshold_q  <= THR_RESET;
            prdata                <= 32'h0;
        end else begin
            if (apb_wr && hit_a2b_ae) begin
                a2b_empty_threshold_q <= pwdata[THR_W-1:0];
            end
            if (apb_wr && hit_a2b_af) begin
                a2b_full_threshold_q <= pwdata[THR_W-1:0];
            end
            if (apb_wr && hit_b2a_ae) begin
                b2a_empty_threshold_q <= pwdata[THR_W-1:0];
            end
            if (apb_wr && hit_b2a_af) begin
                b2a_full_threshold_q <= pwdata[THR_W-1:0];
            end
            if (apb_setup) begin
                prdata <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [DATA_W-1:0] a2b_rd_data, b2a_rd_data;
    logic              a2b_in_ready, a2b_af_n, a2b_out_ready, a2b_ae_n;
    logic              b2a_in_ready, b2a_af_n, b2a_out_ready, b2a_ae_n;

    dcbf_queue u_a_to_b_queue (
        .wclk           (pclk),
        .wrst_n         (a_rst_n),
        .wr_en          (a_wr & ~side_a_in.mailbox_sel),
        .wr_data        (side_a_in.data),
        .full_thr       (a2b_full_threshold_q),
        .in_ready       (a2b_in_ready),
        .almost_full_n  (a2b_af_n),
        .wr_count       (a2b_count),
        .rclk           (side_b_clock),
        .rrst_n         (b_rst_n),
        .rd_en          (b_rd & ~side_b_in.mailbox_sel),
        .empty_thr      (a2b_empty_threshold_q),
        .rd_data        (a2b_rd_data),
        .out_ready      (a2b_out_ready),
        .almost_empty_n (a2b_ae_n),
        .rd_count       ()
    );

    dcbf_queue u_b_to_a_queue (
        .wclk           (side_b_clock),
        .wrst_n         (b_rst_n),
        .wr_en          (b_wr & ~side_b_in.mailbox_sel),
        .wr_data        (side_b_in.data),
        .full_thr       (b2a_full_threshold_q),
        .in_ready       (b2a_in_ready),
        .almost_full_n  (b2a_af_n),
        .wr_count       (),
        .rclk           (pclk),
        .rrst_n         (a_rst_n),
        .rd_en          (a_rd & ~side_a_in.mailbox_sel),
        .empty_thr      (b2a_empty_threshold_q),
        .rd_data        (b2a_rd_data),
        .out_ready      (b2a_out_ready),
        .almost_empty_n (b2a_ae_n),
        .rd_count       (b2a_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Mailboxes hand over by toggles: the writer flips one bit per letter and
    // the reader flips its own when it collects, so no pulse can be missed.
    logic [DATA_W-1:0] mail1_q, mail2_q;
    logic m1_wt_q, m1_rt_q, m1_wt_s1_q, m1_wt_s2_q, m1_rt_s1_q, m1_rt_s2_q;
    logic m2_wt_q, m2_rt_q, m2_wt_s1_q, m2_wt_s2_q, m2_rt_s1_q, m2_rt_s2_q;
    logic a2b_mailbox_full_n, b2a_mailbox_full_n, m1_write, m2_write, m1_take, m2_take;

    assign a2b_mailbox_full_n = m1_wt_q == m1_rt_s2_q;
    assign b2a_mailbox_full_n = m2_wt_q == m2_rt_s2_q;
    assign m1_write = a_wr & side_a_in.mailbox_sel & a2b_mailbox_full_n;
    assign m2_write = b_wr & side_b_in.mailbox_sel & b2a_mailbox_full_n;
    assign m1_take  = b_rd & side_b_in.mailbox_sel & (m1_wt_s2_q != m1_rt_q);
    assign m2_take  = a_rd & side_a_in.mailbox_sel & (m2_wt_s2_q != m2_rt_q);

    always_ff @(posedge pclk or negedge a_rst_n) begin
        if (!a_rst_n) begin
            mail1_q    <= '0;
            m1_wt_q    <= 1'b0;
            m1_rt_s1_q <= 1'b0;
            m1_rt_s2_q <= 1'b0;
            m2_rt_q    <= 1'b0;
            m2_wt_s1_q <= 1'b0;
            m2_wt_s2_q <= 1'b0;
        end else begin
            if (m1_write) begin
                mail1_q <= side_a_in.data;
            end
            m1_wt_q    <= m1_wt_q ^ m1_write;
            m1_rt_s1_q <= m1_rt_q;
            m1_rt_s2_q <= m1_rt_s1_q;
            m2_rt_q    <= m2_rt_q ^ m2_take;
            m2_wt_s1_q <= m2_wt_q;
            m2_wt_s2_q <= m2_wt_s1_q;
        end
    end

    always_ff @(posedge side_b_clock or negedge b_rst_n) begin
        if (!b_rst_n) begin
            mail2_q    <= '0;
            m2_wt_q    <= 1'b0;
            m2_rt_s1_q <= 1'b0;
            m2_rt_s2_q <= 1'b0;
            m1_rt_q    <= 1'b0;
            m1_wt_s1_q <= 1'b0;
            m1_wt_s2_q <= 1'b0;
        end else begin
            if (m2_write) begin
                mail2_q <= side_b_in.data;
            end
            m2_wt_q    <= m2_wt_q ^ m2_write;
            m2_rt_s1_q <= m2_rt_q;
            m2_rt_s2_q <= m2_rt_s1_q;
            m1_rt_q    <= m1_rt_q ^ m1_take;
            m1_wt_s1_q <= m1_wt_q;
            m1_wt_s2_q <= m1_wt_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // side A and side B bus drive
    assign side_a_out.data           = side_a_in.mailbox_sel ? mail2_q : b2a_rd_data;
    assign side_a_out.data_oe        = ~side_a_in.select_n & ~side_a_in.write_sel;
    assign side_a_out.input_ready    = a2b_in_ready;
    assign side_a_out.almost_full    = a2b_af_n;
    assign side_a_out.output_ready   = b2a_out_ready;
    assign side_a_out.almost_empty   = b2a_ae_n;
    assign side_a_out.mailbox_full_n = a2b_mailbox_full_n;

    assign side_b_out.data           = side_b_in.mailbox_sel ? mail1_q : a2b_rd_data;
    assign side_b_out.data_oe        = ~side_b_in.select_n & ~side_b_in.write_sel;
    assign side_b_out.input_ready    = b2a_in_ready;
    assign side_b_out.almost_full    = b2a_af_n;
    assign side_b_out.output_ready   = a2b_out_ready;
    assign side_b_out.almost_empty   = a2b_ae_n;
    assign side_b_out.mailbox_full_n = b2a_mailbox_full_n;

    ////////////////////////////////////////////////////////////////////////////
    sequence s_mail1_posted;
        m1_write ##1 !a2b_mailbox_full_n;
    endsequence

    a_mail_flag_falls: assert property (@(posedge pclk) disable iff (!a_rst_n)
        m1_write |-> s_mail1_posted) else $error("mailbox flag did not fall on write");
    a_mail_write_blocked: assert property (@(posedge pclk) disable iff (!a_rst_n)
        (!a2b_mailbox_full_n && a_wr && side_a_in.mailbox_sel) |=> $stable(mail1_q))
        else $error("mailbox overwritten while full");
    a_a_bus_released: assert property (@(posedge pclk) disable iff (!a_rst_n)
        side_a_in.select_n |-> !side_a_out.data_oe) else $error("side A bus driven while deselected");
    a_b_bus_released: assert property (@(posedge side_b_clock) disable iff (!b_rst_n)
        side_b_in.select_n |-> !side_b_out.data_oe) else $error("side B bus driven while deselected");
    a_offset_written: assert property (@(posedge pclk) disable iff (!presetn)
        (apb_wr && hit_b2a_af) |=> b2a_full_threshold_q == $past(pwdata[THR_W-1:0]))
        else $error("offset write lost");

endmodule : dcbf_top

// [logic/dcbf_pkg.sv]
// Shared constants, carrier types and pointer helpers for the two-way queue buffer.
package dcbf_pkg;

    localparam int DATA_W   = 36;
    localparam int PTR_W    = 9;
    localparam int CNT_W    = 10;
    localparam int THR_W    = 9;
    localparam int PADDR_W  = 8;

    localparam logic [CNT_W-1:0]   DEPTH_CNT  = 10'h200;
    localparam logic [THR_W-1:0]   THR_RESET  = 9'h008;

    localparam logic [PADDR_W-1:0] OFF_A2B_AE = 8'h00;
    localparam logic [PADDR_W-1:0] OFF_A2B_AF = 8'h04;
    localparam logic [PADDR_W-1:0] OFF_B2A_AE = 8'h08;
    localparam logic [PADDR_W-1:0] OFF_B2A_AF = 8'h0C;
    localparam logic [PADDR_W-1:0] OFF_STATUS = 8'h10;

    localparam int ST_A2B_CNT = 0;
    localparam int ST_B2A_CNT = 16;

    typedef struct packed {
        logic              select_n;
        logic              transfer_gate;
        logic              write_sel;
        logic              mailbox_sel;
        logic [DATA_W-1:0] data;
    } dcbf_side_in_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              data_oe;
        logic              input_ready;
        logic              output_ready;
        logic              almost_full;
        logic              almost_empty;
        logic              mailbox_full_n;
    } dcbf_side_out_t;

    function automatic logic [CNT_W-1:0] dcbf_bin2gray(input logic [CNT_W-1:0] b);
        return (b >> 1) ^ b;
    endfunction : dcbf_bin2gray

    function automatic logic [CNT_W-1:0] dcbf_gray2bin(input logic [CNT_W-1:0] g);
        logic [CNT_W-1:0] b;
        b[CNT_W-1] = g[CNT_W-1];
        for (int i = CNT_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : dcbf_gray2bin

endpackage : dcbf_pkg

// [logic/dcbf_queue.sv]
// One 512-word queue with independent write and read clocks and synchronised flags.
module dcbf_queue (
    // Write side
    input  wire logic                         wclk,
    input  wire logic                         wrst_n,
    input  wire logic                         wr_en,
    input  wire logic [dcbf_pkg::DATA_W-1:0]  wr_data,
    input  wire logic [dcbf_pkg::THR_W-1:0]   full_thr,
    output logic                              in_ready,
    output logic                              almost_full_n,
    output logic      [dcbf_pkg::CNT_W-1:0]   wr_count,
    // Read side
    input  wire logic                         rclk,
    input  wire logic                         rrst_n,
    input  wire logic                         rd_en,
    input  wire logic [dcbf_pkg::THR_W-1:0]   empty_thr,
    output logic      [dcbf_pkg::DATA_W-1:0]  rd_data,
    output logic                              out_ready,
    output logic                              almost_empty_n,
    output logic      [dcbf_pkg::CNT_W-1:0]   rd_count
);
    import dcbf_pkg::*;

    logic [DATA_W-1:0] mem [2**PTR_W];

    ////////////////////////////////////////////////////////////////////////////
    logic [CNT_W-1:0] wbin_q, wgray_q, rgray_s1_q, rgray_s2_q, used_w;
    logic [CNT_W-1:0] rbin_q, rgray_q;
    logic [THR_W-1:0] fthr_s1_q, fthr_s2_q;
    logic             wr_fire;
    logic [CNT_W-1:0] wbin_d;

    assign wr_fire = wr_en & in_ready;
    assign wbin_d  = wbin_q + CNT_W'(wr_fire);
    assign used_w  = wbin_d - dcbf_gray2bin(rgray_s2_q);

    always_ff @(posedge wclk or negedge wrst_n) begin
        if (!wrst_n) begin
            wbin_q        <= '0;
            wgray_q       <= '0;
            rgray_s1_q    <= '0;
            rgray_s2_q    <= '0;
            fthr_s1_q     <= THR_RESET;
            fthr_s2_q     <= THR_RESET;
            in_ready      <= 1'b0;
            almost_full_n <= 1'b0;
            wr_count      <= '0;
        end else begin
            wbin_q        <= wbin_d;
            wgray_q       <= dcbf_bin2gray(wbin_d);
            rgray_s1_q    <= rgray_q;
            rgray_s2_q    <= rgray_s1_q;
            fthr_s1_q     <= full_thr;
            fthr_s2_q     <= fthr_s1_q;
            in_ready      <= used_w != DEPTH_CNT;
            almost_full_n <= (DEPTH_CNT - used_w) > {1'b0, fthr_s2_q};
            wr_count      <= used_w;
        end
    end

    // The array carries no reset, so it maps onto plain dual-port memory.
    always_ff @(posedge wclk) begin
        if (wr_fire) begin
            mem[wbin_q[PTR_W-1:0]] <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [CNT_W-1:0] wgray_s1_q, wgray_s2_q, wbin_r, rbin_d, words;
    logic [THR_W-1:0] ethr_s1_q, ethr_s2_q;
    logic             take, out_ready_d;

    assign wbin_r      = dcbf_gray2bin(wgray_s2_q);
    assign take        = (wbin_r != rbin_q) & (~out_ready | rd_en);
    assign out_ready_d = take | (out_ready & ~rd_en);
    assign rbin_d      = rbin_q + CNT_W'(take);
    assign words       = wbin_r - rbin_d + CNT_W'(out_ready_d);

    always_ff @(posedge rclk or negedge rrst_n) begin
        if (!rrst_n) begin
            rbin_q         <= '0;
            rgray_q        <= '0;
            wgray_s1_q     <= '0;
            wgray_s2_q     <= '0;
            ethr_s1_q      <= THR_RESET;
            ethr_s2_q      <= THR_RESET;
            out_ready      <= 1'b0;
            almost_empty_n <= 1'b0;
            rd_count       <= '0;
        end else begin
            rbin_q         <= rbin_d;
            // A slot is freed only when its word leaves the output register, so that
            // register counts toward the depth; the pointer steps by one at most.
            rgray_q        <= dcbf_bin2gray(rbin_d - CNT_W'(out_ready_d));
            wgray_s1_q     <= wgray_q;
            wgray_s2_q     <= wgray_s1_q;
            ethr_s1_q      <= empty_thr;
            ethr_s2_q      <= ethr_s1_q;
            out_ready      <= out_ready_d;
            almost_empty_n <= words > {1'b0, ethr_s2_q};
            rd_count       <= words;
        end
    end

    always_ff @(posedge rclk) begin
        if (take) begin
            rd_data <= mem[rbin_q[PTR_W-1:0]];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_full_blocks_write: assert property (@(posedge wclk) disable iff (!wrst_n)
        !in_ready |=> $stable(wbin_q)) else $error("write accepted while queue full");
    a_full_forces_af: assert property (@(posedge wclk) disable iff (!wrst_n)
        !in_ready |-> !almost_full_n) else $error("almost-full high while full");
    a_empty_forces_ae: assert property (@(posedge rclk) disable iff (!rrst_n)
        !out_ready |-> !almost_empty_n) else $error("almost-empty high while empty");
    a_or_rises_promptly: assert property (@(posedge rclk) disable iff (!rrst_n)
        (!out_ready && wbin_r != rbin_q) |=> out_ready) else $error("output ready late");

endmodule : dcbf_queue

// [tb/dcbf_side_b_model.sv]
// Side B party model: free-running clock, queue writer, queue and mailbox reader.
module dcbf_side_b_model (
    // Side B pins
    output logic                          side_b_clock,
    output dcbf_pkg::dcbf_side_in_t       side_b_in,
    input  wire dcbf_pkg::dcbf_side_out_t side_b_out,
    // Bench commands
    input  wire logic                     drain,
    input  wire logic                     mail_rd,
    input  wire logic [9:0]               tx_cnt
);
    timeunit 1ns;
    timeprecision 100ps;
    import dcbf_pkg::*;

    logic [DATA_W-1:0] rx_q [$];
    logic [DATA_W-1:0] mail_seen;
    logic [9:0]        sent_q;
    dcbf_side_out_t    out_s;

    // Outputs are taken mid-cycle so the values that the design saw at the edge are used.
    always @(negedge side_b_clock) begin
        out_s = side_b_out;
    end

    initial begin
        side_b_clock = 1'b0;
        forever #13.5 side_b_clock = ~side_b_clock;
    end

    initial begin
        side_b_in = '{1'b1, 1'b0, 1'b0, 1'b0, 36'h0};
        sent_q = '0;
    end

    // select and gate on writes, drains and mailbox reads; data on writes only
    always @(posedge side_b_clock) begin : drive
        logic [9:0] sent;
        logic       busy;
        sent = sent_q;
        if (!side_b_in.select_n && side_b_in.write_sel && out_s.input_ready) begin
            sent = sent + 10'h001;
        end
        if (!side_b_in.select_n && !side_b_in.write_sel && side_b_in.mailbox_sel) begin
            mail_seen <= out_s.data;
        end
        if (!side_b_in.select_n && !side_b_in.write_sel && !side_b_in.mailbox_sel && out_s.output_ready) begin
            rx_q.push_back(out_s.data);
        end
        sent_q <= sent;
        busy = !mail_rd && sent != tx_cnt;
        // Released data is inverted on every idle edge, so it alternates between the inverse of the last word and the last word.
        side_b_in <= '{!(mail_rd || drain || busy), mail_rd || drain || busy, busy, mail_rd,
                       busy ? {26'h2AAAAAA, sent} : ~side_b_in.data};
    end
endmodule : dcbf_side_b_model

// [tb/dcbf_top_tb.sv]
// Self-checking bench for the two-way queue buffer: APB offsets, queues and mailbox.
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
    $display("Error %s expected %0h seen %0h", nm, ex, got); miscompares++; end end
`define WAITA(c) begin @(negedge pclk); for (k = 0; k < 3000 && (c) !== 1'b1; k++) @(negedge pclk); \
    if ((c) !== 1'b1) begin miscompares++; stop_test(); end end
module dcbf_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import dcbf_pkg::*;

    logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, err, drain, mail_rd;
    logic [PADDR_W-1:0]   paddr;
    logic [31:0]          pwdata, prdata, rd;
    logic [9:0]           tx_cnt;
    logic [DATA_W-1:0]    ard;
    wire logic            side_b_clock;
    dcbf_side_in_t        a_in, b_in;
    dcbf_side_out_t       a_out, b_out;
    int                   miscompares, samples_checked, k, n;

    dcbf_top i_dcbf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .side_a_in(a_in), .side_a_out(a_out), .side_b_clock(side_b_clock), .side_b_in(b_in), .side_b_out(b_out));
    dcbf_side_b_model i_dcbf_side_b_model (.side_b_clock(side_b_clock), .side_b_in(b_in), .side_b_out(b_out),
        .drain(drain), .mail_rd(mail_rd), .tx_cnt(tx_cnt));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic stop_test;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    task automatic apb(input logic wr, input logic [PADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 3000; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (pready !== 1'b1) begin
            miscompares++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb

    task automatic a_op(input logic wr, input logic mb, input logic [DATA_W-1:0] d);
        @(posedge pclk);
        a_in <= '{1'b0, 1'b1, wr, mb, d};
        @(negedge pclk);
        ard = a_out.data;
        if (!wr) `CHK("a data_oe", 1'b1, a_out.data_oe)
        @(posedge pclk);
        a_in <= '{1'b1, 1'b0, 1'b0, 1'b0, ~d};
    endtask : a_op

    task automatic t_regs;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            `CHK("offset reset", {23'h0, THR_RESET}, rd)
        end
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        apb(1'b1, OFF_STATUS, 32'hFFFFFFFF);
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("status", 32'h0, rd)
        apb(1'b1, OFF_B2A_AE, 32'h2);
        apb(1'b0, OFF_B2A_AE, 32'h0);
        `CHK("b2a empty offset", 32'h2, rd)
        `CHK("a released", 1'b0, a_out.data_oe)
    endtask : t_regs

    task automatic t_a2b;
        `CHK("a almost_full idle", 1'b1, a_out.almost_full)
        n = 0;
        @(posedge pclk);
        a_in <= '{1'b0, 1'b1, 1'b1, 1'b0, 36'h0};
        for (int i = 0; i < 540; i++) begin
            @(negedge pclk);
            if (a_out.input_ready === 1'b1) begin
                n++;
            end
            @(posedge pclk);
            a_in.data <= 36'(n);
        end
        @(posedge pclk);
        a_in <= '{1'b1, 1'b0, 1'b0, 1'b0, ~a_in.data};
        `CHK("a2b taken", 512, n)
        `CHK("a input_ready full", 1'b0, a_out.input_ready)
        `CHK("a almost_full full", 1'b0, a_out.almost_full)
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("a2b used", DEPTH_CNT, rd[9:0])
        `WAITA(b_out.almost_empty)
        drain <= 1'b1;
        `WAITA(i_dcbf_side_b_model.rx_q.size() == 512)
        drain <= 1'b0;
        for (int i = 0; i < 512; i++) `CHK("a2b word", 36'(i), i_dcbf_side_b_model.rx_q[i])
        `WAITA(a_out.almost_full)
        `CHK("b almost_empty drained", 1'b0, b_out.almost_empty)
    endtask : t_a2b

    task automatic t_mail;
        a_op(1'b1, 1'b1, 36'h912345678);
        @(negedge pclk);
        `CHK("mail flag set", 1'b0, a_out.mailbox_full_n)
        a_op(1'b1, 1'b1, 36'h0000000FF);
        mail_rd <= 1'b1;
        `WAITA(a_out.mailbox_full_n)
        mail_rd <= 1'b0;
        `CHK("mail word", 36'h912345678, i_dcbf_side_b_model.mail_seen)
    endtask : t_mail

    task automatic t_b2a;
        tx_cnt <= 10'd3;
        `WAITA(a_out.almost_empty)
        for (int i = 0; i < 3; i++) begin
            `WAITA(a_out.output_ready)
            a_op(1'b0, 1'b0, 36'h0);
            `CHK("b2a word", {26'h2AAAAAA, 10'(i)}, ard)
        end
        `WAITA(a_out.output_ready === 1'b0)
        `CHK("a almost_empty low", 1'b0, a_out.almost_empty)
    endtask : t_b2a

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, drain, mail_rd} = '0;
        {paddr, pwdata, tx_cnt} = '0;
        a_in = '{1'b1, 1'b0, 1'b0, 1'b0, 36'h0};
        repeat (4) @(posedge pclk);
        `CHK("a input_ready reset", 1'b0, a_out.input_ready)
        `CHK("a mail flag reset", 1'b1, a_out.mailbox_full_n)
        presetn <= 1'b1;
        `WAITA(a_out.input_ready)
        `WAITA(b_out.input_ready)
        `CHK("b mail flag idle", 1'b1, b_out.mailbox_full_n)
        `CHK("b almost_full idle", 1'b1, b_out.almost_full)
        t_regs();
        t_a2b();
        t_mail();
        t_b2a();
        stop_test();
    end
endmodule : dcbf_top_tb
